// *** design/tsr_pkg.sv ***
// Constants and carriers for the touch status and LED setup register bank
// Contract
// [R1] Current button states at 04h and 05h
// [R2] State bit reads 1 touched, 0 released
// [R3] Latched button states at 07h and 08h
// [R4] Stored checksum: high 1Ah, low 1Bh
// [R5] Stored checksum sums stored configuration registers
// [R6] Committed settings become the new defaults
// [R7] Live checksum: high 1Ch, low 1Dh
// [R8] Live checksum sums live configuration registers
// [R9] Offset 1Eh returns fixed identity code
// [R10] Offset 1Fh returns fixed program revision
// [R11] LED setup register field layout at 01h
// [R12] Three-bit mode selects map; 101-111 invalid
// [R13] Latched bit holds until host reads it
// [R14] Checksums are 16-bit wrapping sums, split
package tsr_pkg;
	localparam int unsigned BUTTONS   = 10;
	localparam int unsigned MODE_W    = 3;
	localparam int          CFG_FIRST = 1;
	localparam int          CFG_LAST  = 7;
	localparam logic [3:0]  BYTE_BITS = 4'h8;

	// Offsets shared by all maps and the operating map
	localparam logic [7:0] OFF_MODE      = 8'h00;
	localparam logic [7:0] OFF_NOW_LO    = 8'h04;
	localparam logic [7:0] OFF_NOW_HI    = 8'h05;
	localparam logic [7:0] OFF_HELD_LO   = 8'h07;
	localparam logic [7:0] OFF_HELD_HI   = 8'h08;
	localparam logic [7:0] OFF_STORED_HI = 8'h1A;
	localparam logic [7:0] OFF_STORED_LO = 8'h1B;
	localparam logic [7:0] OFF_LIVE_HI   = 8'h1C;
	localparam logic [7:0] OFF_LIVE_LO   = 8'h1D;
	localparam logic [7:0] OFF_PART_ID   = 8'h1E;
	localparam logic [7:0] OFF_REVISION  = 8'h1F;

	// LED map: setup, four fade periods, two dimming bytes
	localparam logic [7:0] OFF_LED_FIRST = 8'h01;
	localparam logic [7:0] OFF_LED_LAST  = 8'h07;

	// Map select codes
	localparam logic [2:0] MODE_OPERATING  = 3'h0;
	localparam logic [2:0] MODE_LED        = 3'h1;
	localparam logic [2:0] MODE_DEVICE     = 3'h2;
	localparam logic [2:0] MODE_TEST       = 3'h3;
	localparam logic [2:0] MODE_DEBUG      = 3'h4;
	localparam logic [2:0] MODE_LAST_VALID = MODE_DEBUG;

	// Reset values
	localparam logic [2:0]  MODE_RESET = MODE_OPERATING;
	localparam logic [7:0]  CFG_RESET  = 8'h00;
	localparam logic [15:0] SUM_BASE   = 16'h003B;

	// LED setup byte, bit 7 first
	typedef struct packed {
		logic       last_btn_fx_en;
		logic       analog_out_en;
		logic [1:0] standby_bright;
		logic       on_time_en;
		logic       touch_fx_en;
		logic       pwron_fx_en;
		logic       pwron_seq;
	} led_setup_s;

	// One register access from the serial port
	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_access_s;
endpackage

// *** design/i2c_target_port.sv ***
`timescale 1ns/1ns
// Serial target port: pointer byte, auto-increment writes and reads
module i2c_target_port #(
	parameter logic [6:0] TARGET_ADDR = 7'h2C
) (
	input  wire logic                clk_sys_i,
	input  wire logic                rst_n_i,
	input  wire logic                scl_i,
	input  wire logic                sda_i,
	output logic                     sda_oe_o,
	input  wire logic [7:0]          rd_data_i,
	output logic [7:0]               ptr_o,
	output tsr_pkg::reg_access_s     wr_o,
	output tsr_pkg::reg_access_s     rd_o
);
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_RX, ST_ACK_RX, ST_TX, ST_ACK_TX} phase_e;

	logic [1:0]           scl_sync_q;
	logic [1:0]           sda_sync_q;
	logic                 scl_prev_q;
	logic                 sda_prev_q;
	phase_e               phase_q, phase_d;
	logic [3:0]           bits_q, bits_d;
	logic [7:0]           shift_q, shift_d;
	logic [7:0]           ptr_q, ptr_d;
	logic                 rw_q, rw_d;
	logic                 first_q, first_d;
	logic                 oe_q, oe_d;
	tsr_pkg::reg_access_s wr_q, wr_d;
	tsr_pkg::reg_access_s rd_q, rd_d;
	logic                 scl_s, sda_s, start, stop, rise, fall;

	// Bus conditions seen on the synchronised pins
	assign scl_s = scl_sync_q[1];
	assign sda_s = sda_sync_q[1];
	assign start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
	assign stop  = scl_s && scl_prev_q && !sda_prev_q && sda_s;
	assign rise  = scl_s && !scl_prev_q;
	assign fall  = !scl_s && scl_prev_q;

	// Byte sequencer
	always_comb begin
		phase_d = phase_q;
		bits_d  = bits_q;
		shift_d = shift_q;
		ptr_d   = ptr_q;
		rw_d    = rw_q;
		first_d = first_q;
		oe_d    = oe_q;
		wr_d    = '0;
		rd_d    = '0;
		if (start) begin
			phase_d = ST_ADDR;
			bits_d  = 4'h0;
			oe_d    = 1'b0;
		end else if (stop) begin
			phase_d = ST_IDLE;
			oe_d    = 1'b0;
		end else begin
			case (phase_q)
				ST_ADDR, ST_RX: begin
					if (rise) begin
						shift_d = {shift_q[6:0], sda_s};
						bits_d  = bits_q + 4'h1;
					end else if (fall && bits_q == tsr_pkg::BYTE_BITS) begin
						bits_d = 4'h0;
						if (phase_q == ST_ADDR) begin
							if (shift_q[7:1] == TARGET_ADDR) begin
								oe_d    = 1'b1;
								rw_d    = shift_q[0];
								phase_d = ST_ACK_ADDR;
							end else begin
								phase_d = ST_IDLE;
							end
						end else begin
							oe_d    = 1'b1;
							phase_d = ST_ACK_RX;
							first_d = 1'b0;
							if (first_q) begin
								ptr_d = shift_q;
							end else begin
								wr_d  = '{valid: 1'b1, addr: ptr_q, data: shift_q};
								ptr_d = ptr_q + 8'h01;
							end
						end
					end
				end
				ST_ACK_ADDR, ST_ACK_TX: begin
					if (phase_q == ST_ACK_TX && rise && sda_s) begin
						phase_d = ST_IDLE; // Controller declined more data
					end else if (fall) begin
						bits_d = 4'h0;
						if (phase_q == ST_ACK_TX || rw_q) begin
							shift_d = rd_data_i;
							oe_d    = !rd_data_i[7];
							rd_d    = '{valid: 1'b1, addr: ptr_q, data: rd_data_i};
							phase_d = ST_TX;
						end else begin
							oe_d    = 1'b0;
							first_d = 1'b1;
							phase_d = ST_RX;
						end
					end
				end
				ST_ACK_RX: begin
					if (fall) begin
						oe_d    = 1'b0;
						phase_d = ST_RX;
					end
				end
				ST_TX: begin
					if (rise) begin
						bits_d = bits_q + 4'h1;
					end else if (fall) begin
						if (bits_q == tsr_pkg::BYTE_BITS) begin
							oe_d    = 1'b0;
							ptr_d   = ptr_q + 8'h01;
							phase_d = ST_ACK_TX;
						end else begin
							shift_d = {shift_q[6:0], 1'b0};
							oe_d    = !shift_q[6];
						end
					end
				end
				default: begin
					oe_d = 1'b0;
				end
			endcase
		end
	end

	// Pin synchronisers and sequencer state
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			phase_q    <= ST_IDLE;
			bits_q     <= 4'h0;
			shift_q    <= 8'h00;
			ptr_q      <= 8'h00;
			rw_q       <= 1'b0;
			first_q    <= 1'b0;
			oe_q       <= 1'b0;
			wr_q       <= '0;
			rd_q       <= '0;
		end else begin
			scl_sync_q <= {scl_sync_q[0], scl_i};
			sda_sync_q <= {sda_sync_q[0], sda_i};
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
			phase_q    <= phase_d;
			bits_q     <= bits_d;
			shift_q    <= shift_d;
			ptr_q      <= ptr_d;
			rw_q       <= rw_d;
			first_q    <= first_d;
			oe_q       <= oe_d;
			wr_q       <= wr_d;
			rd_q       <= rd_d;
		end
	end

	assign sda_oe_o = oe_q;
	assign ptr_o    = ptr_q;
	assign wr_o     = wr_q;
	assign rd_o     = rd_q;
endmodule

// *** design/touch_status_checksum_regs.sv ***
`timescale 1ns/1ns
// Button status, checksum, identity and LED setup registers behind a serial target port
module touch_status_checksum_regs #(
	parameter logic [6:0] TARGET_ADDR = 7'h2C,
	parameter logic [7:0] PART_ID     = 8'h5C, // Arbitrary value
	parameter logic [7:0] REVISION    = 8'h07  // Arbitrary value
) (
	input  wire logic                        clk_sys_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        scl_i,
	input  wire logic                        sda_i,
	output logic                             sda_o,
	output logic                             sda_oe_o,
	input  wire logic [tsr_pkg::BUTTONS-1:0] button_touch_i,
	input  wire logic                        commit_i,
	input  wire logic                        restore_i,
	output logic [tsr_pkg::MODE_W-1:0]       mode_o,
	output tsr_pkg::led_setup_s              led_setup_o,
	output logic [3:0][7:0]                  fade_period_o,
	output logic [7:0]                       out0_dim_a_o,
	output logic [7:0]                       out0_dim_b_o
);
	logic [7:0]                  ptr;
	tsr_pkg::reg_access_s        wr;
	tsr_pkg::reg_access_s        rd;
	logic [tsr_pkg::MODE_W-1:0]  mode_q, mode_d;
	logic [7:0]                  cfg_q [tsr_pkg::CFG_FIRST:tsr_pkg::CFG_LAST];
	logic [7:0]                  cfg_d [tsr_pkg::CFG_FIRST:tsr_pkg::CFG_LAST];
	logic [7:0]                  stored_q [tsr_pkg::CFG_FIRST:tsr_pkg::CFG_LAST];
	logic [7:0]                  stored_d [tsr_pkg::CFG_FIRST:tsr_pkg::CFG_LAST];
	logic [tsr_pkg::BUTTONS-1:0] now_q, now_d;
	logic [8:0]                  held_q, held_d;
	logic [tsr_pkg::BUTTONS-1:0] press;
	logic                        clr_lo, clr_hi;
	logic [15:0]                 live_sum_q, live_sum_d;
	logic [15:0]                 stored_sum_q, stored_sum_d;
	logic [7:0]                  rd_data_q, rd_data_d;
	logic                        sda_level_q;
	logic                        in_led_range;

	// Serial port: pointer, write pulses, read pulses
	i2c_target_port #(
		.TARGET_ADDR(TARGET_ADDR)
	) i2c_target_port_inst (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.sda_oe_o  (sda_oe_o),
		.rd_data_i (rd_data_q),
		.ptr_o     (ptr),
		.wr_o      (wr),
		.rd_o      (rd)
	);

	// Map select and LED settings, live and stored copies
	always_comb begin
		mode_d   = mode_q;
		cfg_d    = cfg_q;
		stored_d = stored_q;
		if (commit_i) begin
			stored_d = cfg_q; // [R6]
		end
		if (wr.valid && wr.addr == tsr_pkg::OFF_MODE) begin
			if (wr.data[2:0] <= tsr_pkg::MODE_LAST_VALID) begin
				mode_d = wr.data[2:0]; // [R12]
			end
		end
		if (restore_i) begin
			cfg_d = stored_q; // [R6]
		end else if (wr.valid && mode_q == tsr_pkg::MODE_LED && wr.addr >= tsr_pkg::OFF_LED_FIRST
				&& wr.addr <= tsr_pkg::OFF_LED_LAST) begin
			cfg_d[wr.addr[2:0]] = wr.data;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			mode_q   <= tsr_pkg::MODE_RESET;
			cfg_q    <= '{default: tsr_pkg::CFG_RESET};
			stored_q <= '{default: tsr_pkg::CFG_RESET};
		end else begin
			mode_q   <= mode_d;
			cfg_q    <= cfg_d;
			stored_q <= stored_d;
		end
	end

	// Button sampling and latched presses; a new press beats a read clear
	assign press  = button_touch_i & ~now_q;
	assign clr_lo = rd.valid && mode_q == tsr_pkg::MODE_OPERATING && rd.addr == tsr_pkg::OFF_HELD_LO;
	assign clr_hi = rd.valid && mode_q == tsr_pkg::MODE_OPERATING && rd.addr == tsr_pkg::OFF_HELD_HI;

	always_comb begin
		now_d       = button_touch_i; // [R2]
		held_d[7:0] = (clr_lo ? 8'h00 : held_q[7:0]) | press[7:0]; // [R13]
		held_d[8]   = (clr_hi ? 1'b0 : held_q[8]) | press[8]; // [R13]
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			now_q  <= '0;
			held_q <= '0;
		end else begin
			now_q  <= now_d;
			held_q <= held_d;
		end
	end

	// Wrapping sums over the stored and live settings
	always_comb begin
		live_sum_d   = tsr_pkg::SUM_BASE;
		stored_sum_d = tsr_pkg::SUM_BASE;
		for (int i = tsr_pkg::CFG_FIRST; i <= tsr_pkg::CFG_LAST; i++) begin
			live_sum_d   = live_sum_d + {8'h00, cfg_q[i]}; // [R8] [R14]
			stored_sum_d = stored_sum_d + {8'h00, stored_q[i]}; // [R5] [R14]
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			live_sum_q   <= tsr_pkg::SUM_BASE;
			stored_sum_q <= tsr_pkg::SUM_BASE;
		end else begin
			live_sum_q   <= live_sum_d;
			stored_sum_q <= stored_sum_d;
		end
	end

	// Read data for the current pointer in the selected map
	assign in_led_range = ptr >= tsr_pkg::OFF_LED_FIRST && ptr <= tsr_pkg::OFF_LED_LAST;

	always_comb begin
		rd_data_d = 8'h00;
		if (ptr == tsr_pkg::OFF_MODE) begin
			rd_data_d = {5'h00, mode_q}; // [R12]
		end else begin
			case (mode_q)
				tsr_pkg::MODE_OPERATING: begin
					case (ptr)
						tsr_pkg::OFF_NOW_LO:    rd_data_d = now_q[7:0]; // [R1]
						tsr_pkg::OFF_NOW_HI:    rd_data_d = {6'h00, now_q[9:8]}; // [R1]
						tsr_pkg::OFF_HELD_LO:   rd_data_d = held_q[7:0]; // [R3]
						tsr_pkg::OFF_HELD_HI:   rd_data_d = {7'h00, held_q[8]}; // [R3]
						tsr_pkg::OFF_STORED_HI: rd_data_d = stored_sum_q[15:8]; // [R4]
						tsr_pkg::OFF_STORED_LO: rd_data_d = stored_sum_q[7:0]; // [R4]
						tsr_pkg::OFF_LIVE_HI:   rd_data_d = live_sum_q[15:8]; // [R7]
						tsr_pkg::OFF_LIVE_LO:   rd_data_d = live_sum_q[7:0]; // [R7]
						tsr_pkg::OFF_PART_ID:   rd_data_d = PART_ID; // [R9]
						tsr_pkg::OFF_REVISION:  rd_data_d = REVISION; // [R10]
						default:                rd_data_d = 8'h00;
					endcase
				end
				tsr_pkg::MODE_LED: begin
					if (in_led_range) begin
						rd_data_d = cfg_q[ptr[2:0]];
					end
				end
				default: begin
					rd_data_d = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rd_data_q   <= 8'h00;
			sda_level_q <= 1'b0;
		end else begin
			rd_data_q   <= rd_data_d;
			sda_level_q <= 1'b0; // Open drain: only ever pulls low
		end
	end

	// Register-backed outputs
	assign sda_o         = sda_level_q;
	assign mode_o        = mode_q;
	assign led_setup_o   = tsr_pkg::led_setup_s'(cfg_q[1]); // [R11]
	assign fade_period_o = {cfg_q[5], cfg_q[4], cfg_q[3], cfg_q[2]};
	assign out0_dim_a_o  = cfg_q[6];
	assign out0_dim_b_o  = cfg_q[7];

	// Checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_op_ptr(logic [7:0] off);
		mode_q == tsr_pkg::MODE_OPERATING && ptr == off;
	endsequence

	sequence s_setup_write;
		wr.valid && mode_q == tsr_pkg::MODE_LED && wr.addr == tsr_pkg::OFF_LED_FIRST && !restore_i;
	endsequence

	sequence s_map_ptr(logic [2:0] m, logic [7:0] off);
		mode_q == m && ptr == off;
	endsequence

	a_now_read: assert property (s_op_ptr(tsr_pkg::OFF_NOW_LO) |=> rd_data_q == $past(now_q[7:0]) // [R1]
		&& now_q == $past(button_touch_i))
		else $error("current button byte wrong");

	a_held_sets: assert property ((button_touch_i[0] && !now_q[0]) |=> held_q[0]) // [R13]
		else $error("press not latched");

	a_held_keeps: assert property ((held_q[0] && !clr_lo) |=> held_q[0]) // [R13]
		else $error("latched press lost before read");

	a_held_clear: assert property ((clr_lo && press[7:0] == 8'h00) |=> held_q[7:0] == 8'h00) // [R3]
		else $error("latched byte not cleared by read");

	a_stored_sum_read: assert property (s_op_ptr(tsr_pkg::OFF_STORED_HI) |=> rd_data_q == $past(stored_sum_q[15:8])) // [R4]
		else $error("stored checksum high byte wrong");

	a_live_sum_read: assert property (s_op_ptr(tsr_pkg::OFF_LIVE_LO) |=> rd_data_q == $past(live_sum_q[7:0])) // [R7]
		else $error("live checksum low byte wrong");

	a_live_sum_step: assert property (s_setup_write ##1 !restore_i |=> // [R8]
		live_sum_q == 16'($past(live_sum_q) + cfg_q[1] - $past(cfg_q[1], 2)))
		else $error("live checksum did not follow write");

	a_commit_sum: assert property (commit_i |=> ##1 stored_sum_q == $past(live_sum_q)) // [R5]
		else $error("stored checksum differs after commit");

	a_restore_cfg: assert property (restore_i |=> cfg_q[1] == $past(stored_q[1])) // [R6]
		else $error("restore did not reload defaults");

	a_part_id: assert property (s_op_ptr(tsr_pkg::OFF_PART_ID) |=> rd_data_q == PART_ID) // [R9]
		else $error("identity code wrong");

	a_revision: assert property (s_op_ptr(tsr_pkg::OFF_REVISION) |=> rd_data_q == REVISION) // [R10]
		else $error("revision code wrong");

	a_setup_field: assert property (s_setup_write |=> led_setup_o.standby_bright == $past(wr.data[5:4])) // [R11]
		else $error("standby brightness field misplaced");

	a_mode_invalid: assert property ((wr.valid && wr.addr == tsr_pkg::OFF_MODE // [R12]
		&& wr.data[2:0] > tsr_pkg::MODE_LAST_VALID) |=> $stable(mode_q))
		else $error("invalid mode accepted");

	a_sum_reset: assert property ($rose(rst_n_i) |-> live_sum_q == tsr_pkg::SUM_BASE) // [R14]
		else $error("checksum reset value wrong");

	// Status reads, one clock behind the pointer
	a_now_high_read: assert property (s_op_ptr(tsr_pkg::OFF_NOW_HI) // [R1]
		|=> rd_data_q == {6'h00, $past(now_q[9:8])})
		else $error("current button high byte wrong");

	a_now_follows: assert property (1'b1 // [R2]
		|=> now_q == $past(button_touch_i))
		else $error("button state not sampled");

	a_held_low_read: assert property (s_op_ptr(tsr_pkg::OFF_HELD_LO) // [R3]
		|=> rd_data_q == $past(held_q[7:0]))
		else $error("latched low byte wrong");

	a_held_high_read: assert property (s_op_ptr(tsr_pkg::OFF_HELD_HI) // [R3]
		|=> rd_data_q == {7'h00, $past(held_q[8])})
		else $error("latched high byte wrong");

	// Latch for button eight
	a_held_high_sets: assert property ((button_touch_i[8] && !now_q[8]) // [R13]
		|=> held_q[8])
		else $error("press of button eight not latched");

	a_held_high_clear: assert property ((clr_hi && !press[8]) // [R13]
		|=> !held_q[8])
		else $error("latched high byte not cleared by read");

	// Remaining checksum bytes
	a_stored_low_read: assert property (s_op_ptr(tsr_pkg::OFF_STORED_LO) // [R4]
		|=> rd_data_q == $past(stored_sum_q[7:0]))
		else $error("stored checksum low byte wrong");

	a_live_high_read: assert property (s_op_ptr(tsr_pkg::OFF_LIVE_HI) // [R7]
		|=> rd_data_q == $past(live_sum_q[15:8]))
		else $error("live checksum high byte wrong");

	// Stored copy moves only on commit
	a_commit_store: assert property (commit_i // [R6]
		|=> stored_q[1] == $past(cfg_q[1]))
		else $error("commit did not store setup byte");

	a_stored_keeps: assert property (!commit_i // [R6]
		|=> $stable(stored_q[1]))
		else $error("stored setup byte changed without commit");

	// Map select and map contents
	a_mode_read: assert property ((ptr == tsr_pkg::OFF_MODE) // [R12]
		|=> rd_data_q == {5'h00, $past(mode_q)})
		else $error("map select read wrong");

	a_mode_write: assert property ((wr.valid && wr.addr == tsr_pkg::OFF_MODE // [R12]
		&& wr.data[2:0] <= tsr_pkg::MODE_LAST_VALID) |=> mode_q == $past(wr.data[2:0]))
		else $error("valid map select not taken");

	a_led_map_read: assert property (s_map_ptr(tsr_pkg::MODE_LED, tsr_pkg::OFF_LED_FIRST) // [R11]
		|=> rd_data_q == $past(cfg_q[1]))
		else $error("setup byte read wrong");

	a_other_map_zero: assert property ((mode_q > tsr_pkg::MODE_LED && ptr != tsr_pkg::OFF_MODE) // [R12]
		|=> rd_data_q == 8'h00)
		else $error("unbuilt map read not zero");

	a_op_write_refused: assert property ((wr.valid && mode_q != tsr_pkg::MODE_LED && !restore_i) // [R12]
		|=> $stable(cfg_q[1]))
		else $error("setup byte written outside LED map");
endmodule

// *** verification/i2c_host_model.sv ***
`timescale 1ns/1ns
// Host controller model that drives the serial register port
module i2c_host_model #(
	parameter logic [6:0] ADDR = 7'h2C,
	parameter int         Q    = 8
) (
	input  wire logic       clk_sys_i,
	input  wire logic       sda_i,
	output logic            scl_o,
	output logic            sda_pull_o,
	output logic            rd_done_o,
	output logic [7:0]      rd_byte_o,
	output int              nacks_o
);
	// Idle bus: clock high and still, data released
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
		rd_done_o = 1'b0;
		rd_byte_o = 8'h00;
		nacks_o = 0;
	end

	// Wait whole clocks
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	// One bit, 1 releases the line; level sampled mid-high
	task automatic bit_io(input logic b, output logic s);
		sda_pull_o <= ~b;
		tick(Q);
		scl_o <= 1'b1;
		tick(Q);
		s = sda_i;
		tick(Q);
		scl_o <= 1'b0;
		tick(Q);
	endtask

	// START or repeated START from either clock level
	task automatic start_c();
		sda_pull_o <= 1'b0;
		tick(Q);
		scl_o <= 1'b1;
		tick(Q);
		sda_pull_o <= 1'b1;
		tick(Q);
		scl_o <= 1'b0;
		tick(Q);
	endtask

	// STOP leaves the bus idle
	task automatic stop_c();
		sda_pull_o <= 1'b1;
		tick(Q);
		scl_o <= 1'b1;
		tick(Q);
		sda_pull_o <= 1'b0;
		tick(Q);
	endtask

	// Eight bits MSB first plus the acknowledge bit
	task automatic xfer(input logic [7:0] tx, input logic ack_rel, output logic [7:0] rx, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack_rel, a);
	endtask

	// Byte written by the host; a missing acknowledge is counted
	task automatic wbyte(input logic [7:0] tx);
		logic [7:0] rx;
		logic       a;
		xfer(tx, 1'b1, rx, a);
		if (a) begin
			nacks_o <= nacks_o + 1;
		end
	endtask

	// Pointer byte then burst of data, pointer auto-increments
	task automatic wr(input logic [6:0] ad, input logic [7:0] ptr, input logic [7:0] d[$]);
		start_c();
		wbyte({ad, 1'b0});
		wbyte(ptr);
		foreach (d[i]) begin
			wbyte(d[i]);
		end
		stop_c();
	endtask

	// Burst read from a pointer, last byte not acknowledged
	task automatic rd(input logic [7:0] ptr, input int n);
		logic [7:0] rx;
		logic       a;
		start_c();
		wbyte({ADDR, 1'b0});
		wbyte(ptr);
		start_c();
		wbyte({ADDR, 1'b1});
		for (int i = 0; i < n; i++) begin
			xfer(8'hFF, i == n - 1, rx, a);
			rd_byte_o <= rx;
			rd_done_o <= 1'b1;
			tick(1);
			rd_done_o <= 1'b0;
		end
		stop_c();
	endtask
endmodule

// *** verification/tb_touch_status_checksum_regs.sv ***
`timescale 1ns/1ns
// Self-checking bench for the touch status and LED setup register bank
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin miscompares++; \
	$display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module tb_touch_status_checksum_regs;
	localparam logic [6:0] ADDR = 7'h2C;
	localparam logic [7:0] PART = 8'h6E; // Arbitrary value
	localparam logic [7:0] REV  = 8'h12; // Arbitrary value
	logic                        clk_sys_i;
	logic                        rst_n_i;
	logic                        scl;
	logic                        host_pull;
	wire logic                   sda_w;
	logic                        sda_oe;
	logic                        sda_lvl;
	logic [9:0]                  buttons;
	logic                        commit;
	logic                        restore;
	logic [2:0]                  mode;
	tsr_pkg::led_setup_s         setup;
	logic [3:0][7:0]             fade;
	logic [7:0]                  dim_a;
	logic [7:0]                  dim_b;
	logic                        rd_done;
	logic [7:0]                  rd_byte;
	int                          nacks;
	logic [7:0]                  exp_q[$];
	logic [7:0]                  d[$];
	logic [7:0]                  e;
	logic [9:0]                  b;
	logic [15:0]                 sum;
	int                          seed;
	int                          miscompares;
	int                          n_compared;

	// Open-drain data line with pull-up
	assign sda_w = ~(sda_oe | host_pull);

	touch_status_checksum_regs #(.TARGET_ADDR(ADDR), .PART_ID(PART), .REVISION(REV)) touch_status_checksum_regs_inst (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_lvl), .sda_oe_o(sda_oe),
		.button_touch_i(buttons), .commit_i(commit), .restore_i(restore), .mode_o(mode),
		.led_setup_o(setup), .fade_period_o(fade), .out0_dim_a_o(dim_a), .out0_dim_b_o(dim_b));

	i2c_host_model #(.ADDR(ADDR)) i2c_host_model_inst (
		.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(host_pull),
		.rd_done_o(rd_done), .rd_byte_o(rd_byte), .nacks_o(nacks));

	// Verdict and end of run
	task automatic results();
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// 125 MHz clock
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	// Each read byte is checked against the oldest note
	always @(posedge clk_sys_i) begin
		if (rd_done) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
			`CHK("read byte", e, rd_byte)
		end
	end

	// Hang guard
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		miscompares++;
		results();
	end

	// Main sequence
	initial begin
		rst_n_i = 1'b0;
		buttons = 10'h000;
		commit = 1'b0;
		restore = 1'b0;
		miscompares = 0;
		n_compared = 0;
		seed = 32'hce2d;
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		`CHK("mode after reset", 3'h0, mode)
		`CHK("setup after reset", 8'h00, setup)
		// Checksums, identity and revision from reset
		exp_q = '{8'h00, 8'h3B, 8'h00, 8'h3B, PART, REV};
		i2c_host_model_inst.rd(8'h1A, 6);
		// Current state, then latched state after release
		b = 10'($random(seed));
		buttons <= b;
		repeat (4) @(posedge clk_sys_i);
		exp_q = '{b[7:0], {6'h00, b[9:8]}};
		i2c_host_model_inst.rd(8'h04, 2);
		buttons <= 10'h000;
		repeat (4) @(posedge clk_sys_i);
		exp_q = '{b[7:0], {7'h00, b[8]}};
		i2c_host_model_inst.rd(8'h07, 2);
		exp_q = '{8'h00, 8'h00};
		i2c_host_model_inst.rd(8'h07, 2);
		// Map select, invalid codes refused
		i2c_host_model_inst.wr(ADDR, 8'h00, '{8'h01});
		`CHK("mode led", 3'h1, mode)
		for (int c = 5; c <= 7; c++) begin
			i2c_host_model_inst.wr(ADDR, 8'h00, '{8'(c)});
			`CHK("mode kept", 3'h1, mode)
		end
		// Random LED settings in one burst
		sum = 16'h003B;
		for (int i = 0; i < 7; i++) begin
			d.push_back(8'($random(seed)));
			sum = sum + 16'(d[i]);
		end
		i2c_host_model_inst.wr(ADDR, 8'h01, d);
		`CHK("setup", d[0], setup)
		`CHK("standby", d[0][5:4], setup.standby_bright)
		`CHK("fade", {d[4], d[3], d[2], d[1]}, fade)
		`CHK("dim a", d[5], dim_a)
		`CHK("dim b", d[6], dim_b)
		exp_q = '{8'h01, d[0], d[1], d[2], d[3], d[4], d[5], d[6]};
		i2c_host_model_inst.rd(8'h00, 8);
		// Commit, overwrite, restore back to committed values
		commit <= 1'b1;
		@(posedge clk_sys_i);
		commit <= 1'b0;
		i2c_host_model_inst.wr(ADDR, 8'h01, '{~d[0]});
		`CHK("setup changed", ~d[0], setup)
		restore <= 1'b1;
		@(posedge clk_sys_i);
		restore <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		`CHK("setup restored", d[0], setup)
		// Device map reads zero except the map select
		i2c_host_model_inst.wr(ADDR, 8'h00, '{8'h02});
		exp_q = '{8'h02, 8'h00};
		i2c_host_model_inst.rd(8'h00, 2);
		// Foreign address ignored, operating map refuses LED writes
		i2c_host_model_inst.wr(ADDR ^ 7'h01, 8'h01, '{8'h00});
		i2c_host_model_inst.wr(ADDR, 8'h00, '{8'h00});
		i2c_host_model_inst.wr(ADDR, 8'h01, '{8'h00});
		`CHK("setup kept", d[0], setup)
		`CHK("mode operating", 3'h0, mode)
		exp_q = '{sum[15:8], sum[7:0], sum[15:8], sum[7:0], PART, REV};
		i2c_host_model_inst.rd(8'h1A, 6);
		repeat (4) @(posedge clk_sys_i);
		`CHK("refusals", 3, nacks)
		`CHK("sda level", 1'b0, sda_lvl)
		`CHK("notes left", 0, exp_q.size())
		results();
	end
endmodule
